// [rtl/pbcaf_top.sv]
// Purpose: alternate-function override of port B bits 7..0 and port C bits 6..1
// Assumes: fuses and peripheral controls are static or synchronous to CLOCK
// Notes: pad drive paths are combinational so clock-out survives reset
// How it works
// RULE1 - every pin's raw digital input feeds its own pin-change source
// RULE2 - port B bit 0 input goes to timer 1 capture
// RULE3 - clock-out fuse makes B0 drive divided clock, ignoring port bits
// RULE4 - divided clock stays on B0 during reset
// RULE5 - timer 1 compare A pin also carries its PWM waveform
// RULE6 - MISO split into master input and slave output signals
// RULE7 - MOSI split into master output and slave input signals
// RULE8 - input enable values for B7 and B6 under async timer and clock selection
// RULE9 - B6 pull-up off, input, when internal RC or async timer
// RULE10 - B7 pull-up off, input, when RC and external clock, or async timer
// RULE11 - reset-disable fuse programmed: C6 is ordinary I/O
// RULE12 - fuse unprogrammed: C6 feeds reset circuitry, no general I/O
// RULE13 - C6 as reset pin reads 0 in direction, output and input
// RULE14 - two-wire enable turns C5 into serial clock line
// RULE15 - two-wire enable turns C4 into serial data line
// RULE16 - two-wire pins open drain, input spikes under 50 ns rejected
// RULE17 - input enable follows override value when enabled, else sleep state
// RULE18 - peripheral input taken before port synchroniser
// RULE19 - SPI input-role pins forced input, pull-up from port bit and disable
// RULE20 - B3, B2, B1 output values overridden by SPI or timer compares
// RULE21 - B5..B0 masked pin-change inputs stay enabled in sleep
`timescale 1ns/1ns
`default_nettype none
module pbcaf_top
(
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic SLEEP_ACTIVE,
	input wire logic GLOBAL_PULLUP_DISABLE,
	input wire logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_OUTPUT_BIT,
	input wire logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_DIRECTION_BIT,
	input wire logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_OUTPUT_BIT,
	input wire logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_DIRECTION_BIT,
	input wire logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_PAD_IN,
	input wire logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_PAD_IN,
	input wire logic CLOCK_OUT_FUSE,
	input wire logic RESET_PIN_DISABLE_FUSE,
	input wire logic INTERNAL_RC_SELECTED,
	input wire logic EXTERNAL_CLOCK_SELECTED,
	input wire logic TIMER2_ASYNC_ENABLE,
	input wire logic [pbcaf_pkg::NUM_PINS-1:0] PIN_CHANGE_MASK,
	input wire logic PIN_CHANGE_GROUP0_ENABLE,
	input wire logic PIN_CHANGE_GROUP1_ENABLE,
	input wire logic [pbcaf_pkg::PC_WIDTH-2:0] ADC_DIGITAL_DISABLE,
	input wire logic SERIAL_PERIPH_ENABLE_BIT,
	input wire logic SERIAL_PERIPH_MASTER_SELECT,
	input wire logic SPI_SCK_OUT,
	input wire logic SPI_SLAVE_OUT,
	input wire logic SPI_MASTER_OUT,
	input wire logic TIMER2_COMPARE_A_OUT,
	input wire logic TIMER2_COMPARE_A_ENABLE,
	input wire logic TIMER1_COMPARE_A_OUT,
	input wire logic TIMER1_COMPARE_A_ENABLE,
	input wire logic TIMER1_COMPARE_B_OUT,
	input wire logic TIMER1_COMPARE_B_ENABLE,
	input wire logic DIVIDED_CLOCK_IN,
	input wire logic TWO_WIRE_ENABLE,
	input wire logic TWI_SCL_PULL_LOW,
	input wire logic TWI_SDA_PULL_LOW,
	output logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_PAD_OUT,
	output logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_PAD_OE,
	output logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_PULLUP,
	output logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_PAD_OUT,
	output logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_PAD_OE,
	output logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_PULLUP,
	output logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_DIRECTION_READ,
	output logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_OUTPUT_READ,
	output logic [pbcaf_pkg::PB_WIDTH-1:0] PORTB_INPUT_READ,
	output logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_DIRECTION_READ,
	output logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_OUTPUT_READ,
	output logic [pbcaf_pkg::PC_WIDTH-1:0] PORTC_INPUT_READ,
	output logic [pbcaf_pkg::NUM_PINS-1:0] PIN_CHANGE_SOURCE,
	output logic TIMER1_CAPTURE_INPUT,
	output logic SPI_SCK_IN,
	output logic SPI_MASTER_IN,
	output logic SPI_SLAVE_IN,
	output logic SPI_SELECT_IN,
	output logic TWI_SCL_IN,
	output logic TWI_SDA_IN,
	output logic RESET_PIN_LEVEL
);
	import pbcaf_pkg::*;

	logic rst_meta;
	logic rst_n;
	logic [NUM_PINS-1:0] port_out;
	logic [NUM_PINS-1:0] port_dir;
	logic [NUM_PINS-1:0] pad_in;
	logic [NUM_PINS-1:0] pullup_override_enable;
	logic [NUM_PINS-1:0] pullup_override_value;
	logic [NUM_PINS-1:0] direction_override_enable;
	logic [NUM_PINS-1:0] direction_override_value;
	logic [NUM_PINS-1:0] outval_override_enable;
	logic [NUM_PINS-1:0] outval_override_value;
	logic [NUM_PINS-1:0] input_enable_override_enable;
	logic [NUM_PINS-1:0] input_enable_override_value;
	logic [NUM_PINS-1:0] pad_out;
	logic [NUM_PINS-1:0] pad_oe;
	logic [NUM_PINS-1:0] pull_en;
	logic [NUM_PINS-1:0] di;
	logic [NUM_PINS-1:0] pin_read;
	logic [NUM_PINS-1:0] pc_wake;
	logic [NUM_PINS-1:0] read_mask;
	logic b7_osc;
	logic b6_osc;
	logic spi_slave;
	logic spi_master;
	logic reset_mode;
	logic [1:0] twi_pad;
	// one element per filter so each process owns its own state
	logic twi_cand [2];
	logic twi_filt [2];
	logic [3:0] twi_cnt [2];

	// reset release through two flops
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign port_out = {PORTC_OUTPUT_BIT, PORTB_OUTPUT_BIT};
	assign port_dir = {PORTC_DIRECTION_BIT, PORTB_DIRECTION_BIT};
	assign pad_in = {PORTC_PAD_IN, PORTB_PAD_IN};

	assign b7_osc = (INTERNAL_RC_SELECTED & EXTERNAL_CLOCK_SELECTED) | TIMER2_ASYNC_ENABLE;
	assign b6_osc = INTERNAL_RC_SELECTED | TIMER2_ASYNC_ENABLE;
	assign spi_slave = SERIAL_PERIPH_ENABLE_BIT & ~SERIAL_PERIPH_MASTER_SELECT;
	assign spi_master = SERIAL_PERIPH_ENABLE_BIT & SERIAL_PERIPH_MASTER_SELECT;
	assign reset_mode = ~RESET_PIN_DISABLE_FUSE;
	// masked pin-change pins other than B7 and B6 keep their input alive through sleep
	assign pc_wake = PIN_CHANGE_MASK & {{PC_WIDTH{PIN_CHANGE_GROUP1_ENABLE}},
		{PB_WIDTH{PIN_CHANGE_GROUP0_ENABLE}}};

	always_comb
	begin
		pullup_override_enable = '0;
		pullup_override_value = '0;
		direction_override_enable = '0;
		direction_override_value = '0;
		outval_override_enable = '0;
		outval_override_value = '0;
		input_enable_override_enable = pc_wake; // RULE21
		input_enable_override_value = pc_wake;
		// oscillator pins
		pullup_override_enable[IDX_B7] = b7_osc; // RULE10
		direction_override_enable[IDX_B7] = b7_osc; // RULE10
		input_enable_override_enable[IDX_B7] = b7_osc | pc_wake[IDX_B7];
		input_enable_override_value[IDX_B7] = (INTERNAL_RC_SELECTED | EXTERNAL_CLOCK_SELECTED) & TIMER2_ASYNC_ENABLE; // RULE8
		pullup_override_enable[IDX_B6] = b6_osc; // RULE9
		direction_override_enable[IDX_B6] = b6_osc; // RULE9
		input_enable_override_enable[IDX_B6] = b6_osc | pc_wake[IDX_B6];
		input_enable_override_value[IDX_B6] = INTERNAL_RC_SELECTED & TIMER2_ASYNC_ENABLE; // RULE8
		// SPI: slave inputs on B5, B3, B2; master input on B4
		pullup_override_enable[IDX_B5] = spi_slave; // RULE19
		direction_override_enable[IDX_B5] = spi_slave;
		pullup_override_value[IDX_B5] = port_out[IDX_B5] & ~GLOBAL_PULLUP_DISABLE;
		outval_override_enable[IDX_B5] = spi_master;
		outval_override_value[IDX_B5] = SPI_SCK_OUT;
		pullup_override_enable[IDX_B4] = spi_master; // RULE19
		direction_override_enable[IDX_B4] = spi_master;
		pullup_override_value[IDX_B4] = port_out[IDX_B4] & ~GLOBAL_PULLUP_DISABLE;
		outval_override_enable[IDX_B4] = spi_slave; // RULE6
		outval_override_value[IDX_B4] = SPI_SLAVE_OUT;
		pullup_override_enable[IDX_B3] = spi_slave; // RULE19
		direction_override_enable[IDX_B3] = spi_slave;
		pullup_override_value[IDX_B3] = port_out[IDX_B3] & ~GLOBAL_PULLUP_DISABLE;
		outval_override_enable[IDX_B3] = spi_master | TIMER2_COMPARE_A_ENABLE; // RULE20
		// SPI master output takes priority over the compare output
		outval_override_value[IDX_B3] = spi_master ? SPI_MASTER_OUT : TIMER2_COMPARE_A_OUT; // RULE7
		pullup_override_enable[IDX_B2] = spi_slave; // RULE19
		direction_override_enable[IDX_B2] = spi_slave;
		pullup_override_value[IDX_B2] = port_out[IDX_B2] & ~GLOBAL_PULLUP_DISABLE;
		outval_override_enable[IDX_B2] = TIMER1_COMPARE_B_ENABLE; // RULE20
		outval_override_value[IDX_B2] = TIMER1_COMPARE_B_OUT;
		// compare A output already carries the PWM waveform in PWM modes
		outval_override_enable[IDX_B1] = TIMER1_COMPARE_A_ENABLE; // RULE5
		outval_override_value[IDX_B1] = TIMER1_COMPARE_A_OUT; // RULE20
		// clock out: combinational from the prescaler, untouched by reset
		direction_override_enable[IDX_B0] = CLOCK_OUT_FUSE; // RULE3
		direction_override_value[IDX_B0] = CLOCK_OUT_FUSE; // RULE4
		outval_override_enable[IDX_B0] = CLOCK_OUT_FUSE; // RULE3
		outval_override_value[IDX_B0] = DIVIDED_CLOCK_IN; // RULE4
		// ADC digital disable on C5..C1
		input_enable_override_enable[IDX_C5:IDX_C1] = pc_wake[IDX_C5:IDX_C1] | ADC_DIGITAL_DISABLE;
		// reset pin: pull-up on, forced input, input kept alive
		pullup_override_enable[IDX_C6] = reset_mode; // RULE12
		pullup_override_value[IDX_C6] = reset_mode;
		direction_override_enable[IDX_C6] = reset_mode; // RULE12
		input_enable_override_enable[IDX_C6] = reset_mode | pc_wake[IDX_C6]; // RULE11
		input_enable_override_value[IDX_C6] = reset_mode | pc_wake[IDX_C6];
		// two-wire pins: open drain, only pull low or release
		pullup_override_enable[IDX_C5] = TWO_WIRE_ENABLE; // RULE14
		pullup_override_value[IDX_C5] = port_out[IDX_C5] & ~GLOBAL_PULLUP_DISABLE;
		direction_override_enable[IDX_C5] = TWO_WIRE_ENABLE; // RULE16
		direction_override_value[IDX_C5] = TWI_SCL_PULL_LOW;
		outval_override_enable[IDX_C5] = TWO_WIRE_ENABLE; // RULE14
		pullup_override_enable[IDX_C4] = TWO_WIRE_ENABLE; // RULE15
		pullup_override_value[IDX_C4] = port_out[IDX_C4] & ~GLOBAL_PULLUP_DISABLE;
		direction_override_enable[IDX_C4] = TWO_WIRE_ENABLE; // RULE16
		direction_override_value[IDX_C4] = TWI_SDA_PULL_LOW;
		outval_override_enable[IDX_C4] = TWO_WIRE_ENABLE; // RULE15
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++)
		begin : pin
			pbcaf_pin u_pin
			(
				.clk(CLOCK),
				.rst_n(rst_n),
				.sleep(SLEEP_ACTIVE),
				.global_pullup_disable(GLOBAL_PULLUP_DISABLE),
				.port_out(port_out[g]),
				.port_dir(port_dir[g]),
				.pad_in(pad_in[g]),
				.pullup_override_enable(pullup_override_enable[g]),
				.pullup_override_value(pullup_override_value[g]),
				.direction_override_enable(direction_override_enable[g]),
				.direction_override_value(direction_override_value[g]),
				.outval_override_enable(outval_override_enable[g]),
				.outval_override_value(outval_override_value[g]),
				.input_enable_override_enable(input_enable_override_enable[g]),
				.input_enable_override_value(input_enable_override_value[g]),
				.pad_out(pad_out[g]),
				.pad_oe(pad_oe[g]),
				.pull_en(pull_en[g]),
				.di(di[g]),
				.pin_read(pin_read[g])
			);
		end
	endgenerate

	assign PORTB_PAD_OUT = pad_out[PB_WIDTH-1:0];
	assign PORTB_PAD_OE = pad_oe[PB_WIDTH-1:0];
	assign PORTB_PULLUP = pull_en[PB_WIDTH-1:0];
	assign PORTC_PAD_OUT = pad_out[NUM_PINS-1:PB_WIDTH];
	assign PORTC_PAD_OE = pad_oe[NUM_PINS-1:PB_WIDTH];
	assign PORTC_PULLUP = pull_en[NUM_PINS-1:PB_WIDTH];

	// peripheral inputs come raw; each peripheral synchronises its own
	assign PIN_CHANGE_SOURCE = di; // RULE1
	assign TIMER1_CAPTURE_INPUT = di[IDX_B0]; // RULE2
	assign SPI_SCK_IN = di[IDX_B5]; // RULE18
	assign SPI_MASTER_IN = di[IDX_B4]; // RULE6
	assign SPI_SLAVE_IN = di[IDX_B3]; // RULE7
	assign SPI_SELECT_IN = di[IDX_B2];
	// reset circuitry sees idle high when the pin is plain I/O
	assign RESET_PIN_LEVEL = reset_mode ? pad_in[IDX_C6] : 1'b1; // RULE12

	// clock and reset pins hide their port bits
	always_comb
	begin
		read_mask = '0;
		read_mask[IDX_B7] = b7_osc;
		read_mask[IDX_B6] = b6_osc;
		read_mask[IDX_C6] = reset_mode; // RULE13
	end

	assign PORTB_DIRECTION_READ = PORTB_DIRECTION_BIT & ~read_mask[PB_WIDTH-1:0];
	assign PORTB_OUTPUT_READ = PORTB_OUTPUT_BIT & ~read_mask[PB_WIDTH-1:0];
	assign PORTB_INPUT_READ = pin_read[PB_WIDTH-1:0] & ~read_mask[PB_WIDTH-1:0];
	assign PORTC_DIRECTION_READ = PORTC_DIRECTION_BIT & ~read_mask[NUM_PINS-1:PB_WIDTH];
	assign PORTC_OUTPUT_READ = PORTC_OUTPUT_BIT & ~read_mask[NUM_PINS-1:PB_WIDTH];
	assign PORTC_INPUT_READ = pin_read[NUM_PINS-1:PB_WIDTH] & ~read_mask[NUM_PINS-1:PB_WIDTH];

	// spike filters: a level must hold SPIKE_COUNT + 1 further cycles to pass.
	// at 100 ns sampling this also drops single-sample upsets.
	assign twi_pad = {pad_in[IDX_C5], pad_in[IDX_C4]};
	generate
		for (g = 0; g < 2; g++)
		begin : spike
			always_ff @(posedge CLOCK or negedge rst_n)
			begin
				if (!rst_n)
				begin
					twi_cand[g] <= FILTER_RESET_VALUE;
					twi_cnt[g] <= COUNT_RESET_VALUE;
					twi_filt[g] <= FILTER_RESET_VALUE;
				end
				else if (twi_pad[g] != twi_cand[g])
				begin
					twi_cand[g] <= twi_pad[g];
					twi_cnt[g] <= COUNT_RESET_VALUE;
				end
				else if (twi_cnt[g] < SPIKE_COUNT)
				begin
					twi_cnt[g] <= twi_cnt[g] + 4'h1;
				end
				else
				begin
					twi_filt[g] <= twi_cand[g]; // RULE16
				end
			end
		end
	endgenerate

	assign TWI_SCL_IN = twi_filt[1];
	assign TWI_SDA_IN = twi_filt[0];

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!rst_n);

	clock_out_pin_a: assert property (CLOCK_OUT_FUSE |-> PORTB_PAD_OE[0] // RULE3
		&& PORTB_PAD_OUT[0] == DIVIDED_CLOCK_IN)
		else $error("clock out not on B0");
	clock_out_reset_a: assert property (@(posedge CLOCK) disable iff (1'b0) // RULE4
		(!NRST && CLOCK_OUT_FUSE) |-> PORTB_PAD_OUT[0] == DIVIDED_CLOCK_IN)
		else $error("clock out lost in reset");
	b6_osc_force_a: assert property (b6_osc |-> !PORTB_PULLUP[6] && !PORTB_PAD_OE[6] // RULE9
		&& PORTB_INPUT_READ[6] == 1'b0)
		else $error("B6 not released to oscillator");
	b7_osc_force_a: assert property (b7_osc |-> !PORTB_PULLUP[7] && !PORTB_PAD_OE[7]) // RULE10
		else $error("B7 not released to oscillator");
	b7_input_enable_a: assert property (b7_osc |-> PIN_CHANGE_SOURCE[7] == // RULE8
		(PORTB_PAD_IN[7] & (INTERNAL_RC_SELECTED | EXTERNAL_CLOCK_SELECTED)
		& TIMER2_ASYNC_ENABLE))
		else $error("B7 input enable wrong");
	reset_pin_read_a: assert property (reset_mode |-> PORTC_DIRECTION_READ[5] == 1'b0 // RULE13
		&& PORTC_OUTPUT_READ[5] == 1'b0 && PORTC_INPUT_READ[5] == 1'b0
		&& RESET_PIN_LEVEL == PORTC_PAD_IN[5])
		else $error("reset pin leaks port bits");
	twi_open_drain_a: assert property (TWO_WIRE_ENABLE |-> PORTC_PAD_OUT[4] == 1'b0 // RULE16
		&& PORTC_PAD_OE[4] == TWI_SCL_PULL_LOW)
		else $error("SCL not open drain");
	twi_spike_hold_a: assert property ($changed(TWI_SCL_IN) |-> // RULE16
		$past(PORTC_PAD_IN[4], 1) == TWI_SCL_IN && $past(PORTC_PAD_IN[4], 2) == TWI_SCL_IN)
		else $error("SCL spike passed");
	spi_slave_input_a: assert property (spi_slave |-> !PORTB_PAD_OE[5] // RULE19
		&& PORTB_PULLUP[5] == (PORTB_OUTPUT_BIT[5] & !GLOBAL_PULLUP_DISABLE))
		else $error("SCK not forced input");
	timer_compare_a: assert property (TIMER1_COMPARE_A_ENABLE |-> // RULE20
		PORTB_PAD_OUT[1] == TIMER1_COMPARE_A_OUT)
		else $error("compare A not on B1");
	sleep_input_off_a: assert property ((SLEEP_ACTIVE && !pc_wake[1]) |-> // RULE17
		PIN_CHANGE_SOURCE[1] == 1'b0 ##2 PORTB_INPUT_READ[1] == 1'b0 || SLEEP_ACTIVE == 1'b0)
		else $error("input alive in sleep");
	sleep_wake_on_a: assert property ((SLEEP_ACTIVE && pc_wake[2]) |-> // RULE21
		PIN_CHANGE_SOURCE[2] == PORTB_PAD_IN[2] && TIMER1_CAPTURE_INPUT == PIN_CHANGE_SOURCE[0])
		else $error("masked input off in sleep");

	clock_out_c: cover property (CLOCK_OUT_FUSE && $changed(PORTB_PAD_OUT[0]));
	spi_slave_c: cover property (spi_slave && $changed(SPI_SLAVE_IN));
	twi_edge_c: cover property (TWO_WIRE_ENABLE && $fell(TWI_SDA_IN));
	sleep_wake_c: cover property (SLEEP_ACTIVE && $rose(PIN_CHANGE_SOURCE[3]));
endmodule
`default_nettype wire

// [rtl/pbcaf_pkg.sv]
// Purpose: shared constants for the port B / port C pin override logic
// Assumes: 14 pins, index 0..7 is port B bits 0..7, 8..13 is port C bits 1..6
// Notes: timing counts derive from the system clock period
package pbcaf_pkg;
	localparam int PB_WIDTH = 8;
	localparam int PC_WIDTH = 6;
	localparam int NUM_PINS = 14;
	localparam int PC_LOW_BIT = 1;
	// pin positions within the 14-bit pin vector
	localparam int IDX_B0 = 0;
	localparam int IDX_B1 = 1;
	localparam int IDX_B2 = 2;
	localparam int IDX_B3 = 3;
	localparam int IDX_B4 = 4;
	localparam int IDX_B5 = 5;
	localparam int IDX_B6 = 6;
	localparam int IDX_B7 = 7;
	localparam int IDX_C1 = 8;
	localparam int IDX_C4 = 11;
	localparam int IDX_C5 = 12;
	localparam int IDX_C6 = 13;
	// timing
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int SPIKE_TIME_NS = 50;
	localparam int SPIKE_CYCLES_RAW = (SPIKE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int SPIKE_CYCLES = (SPIKE_CYCLES_RAW < 1) ? 1 : SPIKE_CYCLES_RAW;
	localparam logic [3:0] SPIKE_COUNT = 4'(SPIKE_CYCLES);
	// reset values
	localparam logic SYNC_RESET_VALUE = 1'b0;
	localparam logic FILTER_RESET_VALUE = 1'b1;
	localparam logic [3:0] COUNT_RESET_VALUE = 4'h0;
endpackage

// [rtl/pbcaf_pin.sv]
// Purpose: one pad's override muxes and its input path
// Assumes: pad input is asynchronous to CLOCK
// Notes: digital input to peripherals is taken before the read-back synchroniser
`timescale 1ns/1ns
`default_nettype none
module pbcaf_pin
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sleep,
	input wire logic global_pullup_disable,
	input wire logic port_out,
	input wire logic port_dir,
	input wire logic pad_in,
	input wire logic pullup_override_enable,
	input wire logic pullup_override_value,
	input wire logic direction_override_enable,
	input wire logic direction_override_value,
	input wire logic outval_override_enable,
	input wire logic outval_override_value,
	input wire logic input_enable_override_enable,
	input wire logic input_enable_override_value,
	output logic pad_out,
	output logic pad_oe,
	output logic pull_en,
	output logic di,
	output logic pin_read
);
	import pbcaf_pkg::*;

	logic die;
	logic sync1;

	always_comb
	begin
		pull_en = pullup_override_enable ? pullup_override_value : (port_out & ~port_dir & ~global_pullup_disable);
		pad_oe = direction_override_enable ? direction_override_value : port_dir;
		pad_out = outval_override_enable ? outval_override_value : port_out;
		die = input_enable_override_enable ? input_enable_override_value : ~sleep; // RULE17
		di = pad_in & die; // RULE18
	end

	// two-flop synchroniser for the port's own read-back only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1 <= SYNC_RESET_VALUE;
			pin_read <= SYNC_RESET_VALUE;
		end
		else
		begin
			sync1 <= di;
			pin_read <= sync1;
		end
	end
endmodule
`default_nettype wire

// [dv/pbcaf_far_model.sv]
// Purpose: far side of the pin override block: clock prescaler and pad wires
// Assumes: outside drivers on every pad are strong and always present
// Notes: prescaler has no reset, so the divided clock keeps running in reset
`timescale 1ns/1ns
`default_nettype none
module pbcaf_far_model
(
	input wire logic clk,
	input wire logic [7:0] b_out,
	input wire logic [7:0] b_oe,
	input wire logic [7:0] b_ext,
	input wire logic [5:0] c_out,
	input wire logic [5:0] c_oe,
	input wire logic [5:0] c_ext,
	output logic [7:0] b_pad,
	output logic [5:0] c_pad,
	output logic div_clk
);
	logic tgl = 1'h0;
	always @(posedge clk)
	begin
		tgl <= ~tgl;
	end
	assign div_clk = tgl;
	// a driven pad shows the device level, a released one the outside driver
	assign b_pad = (b_oe & b_out) | (~b_oe & b_ext);
	assign c_pad = (c_oe & c_out) | (~c_oe & c_ext);
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: self-checking bench for the port B / port C pin override block
// Assumes: inputs change at the falling edge, combinational outputs judged 1 ns later, registered ones at the edge
// Notes: read-back and spike filter latencies follow the hand-over figures
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pbcaf_pkg::*;
	logic clk, nrst, slp, global_pullup_disable, cko, rdf, rc, ext, as2, pg0, pg1, serial_periph_enable_bit, serial_periph_master_select, sck, sso, smo;
	logic t2a, t2e, t1a, t1e, t1b, t1be, twe, scl_lo, sda_lo, cap, scki, msi, sli, ssi;
	logic scl, sda, rpl, dclk;
	logic [PB_WIDTH-1:0] bo, bd, bx, bpo, boe, bpu, bdr, bor, bir, bpad;
	logic [PC_WIDTH-1:0] co, cd, cx, cpo, coe, cpu, cdr, cor, cir, cpad;
	logic [NUM_PINS-1:0] pcm, pcs;
	logic [PC_WIDTH-2:0] adcd;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	pbcaf_top pbcaf_top_i (.CLOCK(clk), .NRST(nrst), .SLEEP_ACTIVE(slp),
		.GLOBAL_PULLUP_DISABLE(global_pullup_disable), .PORTB_OUTPUT_BIT(bo), .PORTB_DIRECTION_BIT(bd),
		.PORTC_OUTPUT_BIT(co), .PORTC_DIRECTION_BIT(cd), .PORTB_PAD_IN(bpad), .PORTC_PAD_IN(cpad),
		.CLOCK_OUT_FUSE(cko), .RESET_PIN_DISABLE_FUSE(rdf), .INTERNAL_RC_SELECTED(rc),
		.EXTERNAL_CLOCK_SELECTED(ext), .TIMER2_ASYNC_ENABLE(as2), .PIN_CHANGE_MASK(pcm),
		.PIN_CHANGE_GROUP0_ENABLE(pg0), .PIN_CHANGE_GROUP1_ENABLE(pg1),
		.ADC_DIGITAL_DISABLE(adcd), .SERIAL_PERIPH_ENABLE_BIT(serial_periph_enable_bit),
		.SERIAL_PERIPH_MASTER_SELECT(serial_periph_master_select), .SPI_SCK_OUT(sck), .SPI_SLAVE_OUT(sso),
		.SPI_MASTER_OUT(smo), .TIMER2_COMPARE_A_OUT(t2a), .TIMER2_COMPARE_A_ENABLE(t2e),
		.TIMER1_COMPARE_A_OUT(t1a), .TIMER1_COMPARE_A_ENABLE(t1e), .TIMER1_COMPARE_B_OUT(t1b),
		.TIMER1_COMPARE_B_ENABLE(t1be), .DIVIDED_CLOCK_IN(dclk), .TWO_WIRE_ENABLE(twe),
		.TWI_SCL_PULL_LOW(scl_lo), .TWI_SDA_PULL_LOW(sda_lo), .PORTB_PAD_OUT(bpo),
		.PORTB_PAD_OE(boe), .PORTB_PULLUP(bpu), .PORTC_PAD_OUT(cpo), .PORTC_PAD_OE(coe),
		.PORTC_PULLUP(cpu), .PORTB_DIRECTION_READ(bdr), .PORTB_OUTPUT_READ(bor),
		.PORTB_INPUT_READ(bir), .PORTC_DIRECTION_READ(cdr), .PORTC_OUTPUT_READ(cor),
		.PORTC_INPUT_READ(cir), .PIN_CHANGE_SOURCE(pcs), .TIMER1_CAPTURE_INPUT(cap),
		.SPI_SCK_IN(scki), .SPI_MASTER_IN(msi), .SPI_SLAVE_IN(sli), .SPI_SELECT_IN(ssi),
		.TWI_SCL_IN(scl), .TWI_SDA_IN(sda), .RESET_PIN_LEVEL(rpl));
	pbcaf_far_model pbcaf_far_model_i (.clk(clk), .b_out(bpo), .b_oe(boe), .b_ext(bx),
		.c_out(cpo), .c_oe(coe), .c_ext(cx), .b_pad(bpad), .c_pad(cpad), .div_clk(dclk));
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// whole run is about 70 cycles, the ceiling leaves ample slack
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic t_clkout();
		@(negedge clk);
		{cko, bd[0], bo[0]} = 3'h4;
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
				nrst = 1'h0;
			#1;
			chk("b0 oe", 1'h1, boe[0]);
			chk("b0 clock", dclk, bpo[0]);
			@(negedge clk);
		end
		{nrst, cko} = 2'h2;
		nc(4);
	endtask
	task automatic t_capture();
		@(negedge clk);
		{slp, pcm[IDX_B0], pg0} = 3'h7;
		for (int v = 0; v < 2; v++)
		begin
			@(negedge clk);
			bx[0] = v[0];
			#1;
			chk("b0 source", v[0], pcs[IDX_B0]);
			chk("capture", v[0], cap);
		end
		pcm[IDX_B0] = 1'h0;
		#1;
		chk("b0 asleep", 1'h0, pcs[IDX_B0]);
		slp = 1'h0;
		#1;
		chk("b0 awake", 1'h1, pcs[IDX_B0]);
		pg0 = 1'h0;
	endtask
	task automatic t_compare();
		bd[3:1] = 3'h7;
		{t1e, t1be, t2e} = 3'h7;
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk);
			{t1a, t1b, t2a} = {i[0], ~i[0], i[1]};
			#1;
			chk("b1 out", i[0], bpo[1]);
			chk("b2 out", ~i[0], bpo[2]);
			chk("b3 out", i[1], bpo[3]);
		end
		@(negedge clk);
		{t1e, t1be, t2e} = 3'h0;
		bo[1] = 1'h1;
		#1;
		chk("b1 port", 1'h1, bpo[1]);
	endtask
	task automatic t_spi();
		@(negedge clk);
		{serial_periph_enable_bit, serial_periph_master_select, global_pullup_disable, sso} = 4'h9;
		bd = 8'h3C;
		bo[3] = 1'h1;
		bx[3:2] = 2'h2;
		#1;
		chk("sck oe slave", 1'h0, boe[5]);
		chk("mosi oe slave", 1'h0, boe[3]);
		chk("ss oe slave", 1'h0, boe[2]);
		chk("miso oe slave", 1'h1, boe[4]);
		chk("miso out", 1'h1, bpo[4]);
		chk("mosi pullup", 1'h1, bpu[3]);
		chk("slave in", 1'h1, sli);
		chk("select in", 1'h0, ssi);
		global_pullup_disable = 1'h1;
		#1;
		chk("mosi pullup off", 1'h0, bpu[3]);
		@(negedge clk);
		{serial_periph_master_select, global_pullup_disable, sck, smo} = 4'hB;
		bx[4] = 1'h1;
		#1;
		chk("miso oe master", 1'h0, boe[4]);
		chk("master in", 1'h1, msi);
		chk("sck out", 1'h1, bpo[5]);
		chk("mosi oe master", 1'h1, boe[3]);
		smo = 1'h0;
		#1;
		chk("mosi out", 1'h0, bpo[3]);
		{serial_periph_enable_bit, serial_periph_master_select} = 2'h0;
		bd = 8'h00;
	endtask
	task automatic t_osc();
		logic f6, f7;
		bo[7:6] = 2'h3;
		bx[7:6] = 2'h3;
		for (int k = 0; k < 16; k++)
		begin
			@(negedge clk);
			{rc, ext, as2} = k[2:0];
			bd[7:6] = k[3] ? 2'h1 : 2'h2;
			#1;
			f6 = rc | as2;
			f7 = (rc & ext) | as2;
			chk(k[3] ? "b6 oe" : "b6 pullup", !f6, k[3] ? boe[6] : bpu[6]);
			chk(k[3] ? "b7 pullup" : "b7 oe", !f7, k[3] ? bpu[7] : boe[7]);
			chk("b6 input", f6 ? rc & as2 : 1'h1, pcs[IDX_B6]);
			chk("b7 input", f7 ? (rc | ext) & as2 : 1'h1, pcs[IDX_B7]);
		end
		{rc, ext, as2} = 3'h0;
	endtask
	task automatic t_resetpin();
		@(negedge clk);
		{cd[5], co[5], cx[5]} = 3'h6;
		#1;
		chk("c6 dir read", 1'h0, cdr[5]);
		chk("c6 out read", 1'h0, cor[5]);
		chk("c6 oe", 1'h0, coe[5]);
		chk("reset low", 1'h0, rpl);
		cx[5] = 1'h1;
		nc(3);
		chk("reset high", 1'h1, rpl);
		chk("c6 in read", 1'h0, cir[5]);
		{rdf, co[5], cx[5]} = 3'h4;
		#1;
		chk("c6 oe io", 1'h1, coe[5]);
		chk("c6 out io", 1'h0, cpo[5]);
		chk("reset idle", 1'h1, rpl);
		chk("c6 dir io", 1'h1, cdr[5]);
		co[5] = 1'h1;
		nc(3);
		chk("c6 in io", 1'h1, cir[5]);
	endtask
	task automatic t_twi();
		@(negedge clk);
		{twe, scl_lo, sda_lo} = 3'h6;
		cd[4:3] = 2'h3;
		co[4:3] = 2'h3;
		cx[4:3] = 2'h3;
		#1;
		chk("scl oe", 1'h1, coe[4]);
		chk("scl low", 1'h0, cpo[4]);
		chk("sda released", 1'h0, coe[3]);
		{scl_lo, sda_lo} = 2'h1;
		#1;
		chk("scl released", 1'h0, coe[4]);
		chk("sda oe", 1'h1, coe[3]);
		chk("sda low", 1'h0, cpo[3]);
		sda_lo = 1'h0;
		nc(3);
		// short glitch inside the low clock phase, then a one-cycle pulse
		#10 cx[4] = 1'h0;
		#30 cx[4] = 1'h1;
		@(negedge clk);
		cx[4] = 1'h0;
		@(negedge clk);
		cx[4] = 1'h1;
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk);
			chk("scl spike", 1'h1, scl);
		end
		{cx[4], cx[3]} = 2'h0;
		nc(2);
		chk("scl early", 1'h1, scl);
		nc(1);
		chk("scl settled", 1'h0, scl);
		chk("sda settled", 1'h0, sda);
		cx[4:3] = 2'h3;
		twe = 1'h0;
	endtask
	task automatic t_readback();
		@(negedge clk);
		bx[1] = 1'h1;
		#1;
		chk("b1 source", 1'h1, pcs[IDX_B1]);
		chk("b1 read early", 1'h0, bir[1]);
		nc(1);
		chk("b1 read one", 1'h0, bir[1]);
		nc(1);
		chk("b1 read two", 1'h1, bir[1]);
		slp = 1'h1;
		#1;
		chk("b1 asleep", 1'h0, pcs[IDX_B1]);
		{pcm[IDX_B1], pg0} = 2'h3;
		#1;
		chk("b1 masked", 1'h1, pcs[IDX_B1]);
	endtask
	initial
	begin
		{nrst, slp, global_pullup_disable, cko, rdf, rc, ext, as2, pg0, pg1, serial_periph_enable_bit, serial_periph_master_select, sck, sso, smo} = 15'h0;
		{t2a, t2e, t1a, t1e, t1b, t1be, twe, scl_lo, sda_lo} = 9'h0;
		{bo, bd, bx, co, cd} = 36'h0;
		cx = 6'h3F;
		pcm = 14'h0;
		adcd = 5'h0;
		nc(3);
		nrst = 1'h1;
		nc(3);
		t_clkout();
		t_capture();
		t_compare();
		t_spi();
		t_osc();
		t_resetpin();
		t_twi();
		t_readback();
		conclude();
	end
endmodule
`default_nettype wire
